//--- core/dbg_cfg.svh
// constants of the debug link programming port
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH
`define ADR_PART_ID     8'h00
`define ADR_REV_ID      8'h01
`define ADR_HALT        8'h02
`define ADR_PROG_EN     8'hDF
`define ADR_DATA        8'hBF
`define ADR_LOCK_STAT   8'hB7
`define ADR_ADDR_HI     8'hAF
`define ADR_ADDR_LO     8'hAE
`define ADR_CHECKSUM_BYTE0        8'hA9
`define ADR_CHECKSUM_BYTE1        8'hAA
`define ADR_CHECKSUM_BYTE2        8'hAB
`define ADR_CHECKSUM_BYTE3        8'hAC
`define REG_RESET       8'h00
`define STAT_BUSY_BIT   7
`define STAT_WLOCK_BIT  7
`define STAT_RLOCK_BIT  6
`define STAT_ERR_BIT    0
`define BLOCK_LOW_ADDR  8'h00
`define FULL_START_ADDR 16'h0000
`define BLOCK_BYTES     17'h00100
`define INS_WRITE_BIT   0
`define INS_ADDR_BIT    1
`define INS_LAST_BIT    3'h1
`define BYTE_LAST_BIT   3'h7
`define CLK_PERIOD_NS   40
`define LINK_RESET_NS   20000
`define LINK_RESET_CYC  ((`LINK_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- core/dbg_pkg.sv
// state types of the debug link programming port
package dbg_pkg;
   typedef enum logic [2:0] {FR_IDLE, FR_INS, FR_DIN, FR_TURN, FR_DOUT} frame_state_t;
   typedef enum logic [1:0] {MS_IDLE, MS_LINK_RD, MS_LINK_WR, MS_CRC} mem_state_t;
   typedef enum logic {CRC_IDLE, CRC_RUN} crc_state_t;
endpackage : dbg_pkg

//--- core/crc_if.sv
// checksum request and memory fetch group between core and engine
`timescale 1ns/10ps
`default_nettype none
interface crc_if;
   logic        start;
   logic        wide;
   logic [15:0] base;
   logic [16:0] len;
   logic        mem_req;
   logic [15:0] mem_addr;
   logic        mem_ack;
   logic [7:0]  mem_data;
   logic        busy;
   logic        done;
   logic        res_wide;
   logic [31:0] result;
   modport engine (input start, wide, base, len, mem_ack, mem_data,
                   output mem_req, mem_addr, busy, done, res_wide, result);
   modport core (output start, wide, base, len, mem_ack, mem_data,
                 input mem_req, mem_addr, busy, done, res_wide, result);
endinterface : crc_if
`default_nettype wire

//--- core/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int W = 2
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_pins,
   output var  logic [W-1:0] o_level
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   wire  [W-1:0] agree = s2_reg ~^ s3_reg;
   wire  [W-1:0] level_next = (agree & s3_reg) | (~agree & o_level);

   // pins idle high, first stage feeds only the second
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_reg  <= {W{1'b1}};
         s2_reg  <= {W{1'b1}};
         s3_reg  <= {W{1'b1}};
         o_level <= {W{1'b1}};
      end else begin
         s1_reg  <= i_pins;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         o_level <= level_next;
      end
   end
endmodule : pin_sync
`default_nettype wire

//--- core/crc_engine.sv
// byte-serial checksum engine fetching through the core memory port
`timescale 1ns/10ps
`default_nettype none
module crc_engine
   import dbg_pkg::*;
#(
   parameter logic [15:0] POLY16 = 16'h1021,
   parameter logic [15:0] INIT16 = 16'hFFFF,
   parameter logic [31:0] POLY32 = 32'h04C11DB7,
   parameter logic [31:0] INIT32 = 32'hFFFFFFFF
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   crc_if.engine     bus
);
   crc_state_t  state_reg;
   logic [31:0] crc_reg;
   logic [15:0] addr_reg;
   logic [16:0] left_reg;
   logic        wide_reg;
   logic        done_reg;

   // one byte msb first, narrow mode keeps the upper half clear
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d, input logic w);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = (w ? r[31] : r[15]) ^ d[i];
         r  = {r[30:0], 1'b0};
         if (fb) begin
            r = r ^ (w ? POLY32 : {16'h0000, POLY16});
         end
      end
      if (!w) begin
         r[31:16] = 16'h0000;
      end
      return r;
   endfunction : crc_step

   // walk the range one fetched byte at a time
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= CRC_IDLE;
         crc_reg   <= 32'h00000000;
         addr_reg  <= 16'h0000;
         left_reg  <= 17'h00000;
         wide_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            CRC_IDLE: begin
               if (bus.start) begin
                  state_reg <= CRC_RUN;
                  crc_reg   <= bus.wide ? INIT32 : {16'h0000, INIT16};
                  addr_reg  <= bus.base;
                  left_reg  <= bus.len;
                  wide_reg  <= bus.wide;
               end
            end
            CRC_RUN: begin
               if (bus.mem_ack) begin
                  crc_reg  <= crc_step(crc_reg, bus.mem_data, wide_reg);
                  addr_reg <= addr_reg + 16'h0001;
                  left_reg <= left_reg - 17'h00001;
                  if (left_reg == 17'h00001) begin
                     state_reg <= CRC_IDLE;
                     done_reg  <= 1'b1;
                  end
               end
            end
            default: state_reg <= CRC_IDLE;
         endcase
      end
   end

   assign bus.mem_req  = (state_reg == CRC_RUN);
   assign bus.mem_addr = addr_reg;
   assign bus.busy     = (state_reg == CRC_RUN);
   assign bus.done     = done_reg;
   assign bus.res_wide = wide_reg;
   assign bus.result   = crc_reg;
endmodule : crc_engine
`default_nettype wire

//--- core/dbg_prog_port.sv
// two-wire debug link register port for code memory programming
`timescale 1ns/10ps
`default_nettype none
`include "dbg_cfg.svh"
module dbg_prog_port
   import dbg_pkg::*;
#(
   parameter int          MEM_BYTES = 16384,
   parameter logic [7:0]  PART_ID   = 8'h5A,  // arbitrary value
   parameter logic [7:0]  REV_ID    = 8'h00,  // arbitrary value
   parameter logic [15:0] POLY16    = 16'h1021,
   parameter logic [15:0] INIT16    = 16'hFFFF,
   parameter logic [31:0] POLY32    = 32'h04C11DB7,
   parameter logic [31:0] INIT32    = 32'hFFFFFFFF
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_link_clock_pin,
   input  wire logic        i_link_data_pin,
   output logic             o_link_data_pin,
   output logic             o_link_data_oe,
   output logic             o_core_reset,
   output logic             o_core_halt,
   output logic             o_prog_enable,
   output logic [15:0]      o_lock_addr,
   input  wire logic        i_write_locked,
   input  wire logic        i_read_locked,
   output logic [15:0]      o_mem_addr,
   output logic [7:0]       o_mem_wdata,
   output logic             o_mem_read,
   output logic             o_mem_write,
   input  wire logic [7:0]  i_mem_rdata,
   input  wire logic        i_mem_done
);
   localparam int RST_CYC = `LINK_RESET_CYC;

   // refuse sizes the address and counters cannot serve
   if (MEM_BYTES < 256 || MEM_BYTES > 65536 || (MEM_BYTES % 256) != 0) begin : g_bad_size
      $error("MEM_BYTES must be a multiple of 256 up to 65536");
   end
   if (RST_CYC < 1 || RST_CYC > 1023) begin : g_bad_reset
      $error("link reset count does not fit its counter");
   end

   // ------------------------------------------------------------------
   // pin sampling
   // ------------------------------------------------------------------
   logic [1:0]   pin_level;
   logic         ck_prev_reg;
   logic [9:0]   low_cnt_reg;
   logic         link_reset_reg;

   // reset pin doubles as link clock, data pin is shared
   pin_sync #(
      .W (2)
   ) u_pin_sync (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_pins  ({i_link_clock_pin, i_link_data_pin}),
      .o_level (pin_level)
   );

   wire       link_ck = pin_level[1];
   wire       link_dt = pin_level[0];
   wire       ck_rise = link_ck & ~ck_prev_reg;
   wire       low_full = (low_cnt_reg == 10'(RST_CYC));
   wire [9:0] low_cnt_next = link_ck ? 10'h000 : (low_full ? low_cnt_reg : low_cnt_reg + 10'h001);

   // long low on the clock pin is a device reset
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ck_prev_reg    <= 1'b1;
         low_cnt_reg    <= 10'h000;
         link_reset_reg <= 1'b0;
      end else begin
         ck_prev_reg    <= link_ck;
         low_cnt_reg    <= low_cnt_next;
         link_reset_reg <= (low_cnt_next == 10'(RST_CYC));
      end
   end

   // ------------------------------------------------------------------
   // link frame engine
   // ------------------------------------------------------------------
   frame_state_t fr_state_reg;
   frame_state_t fr_state_next;
   logic [2:0]   bit_cnt_reg;
   logic [2:0]   bit_cnt_next;
   logic [1:0]   ins_reg;
   logic [1:0]   ins_next;
   logic [7:0]   shift_reg;
   logic [7:0]   shift_next;
   logic         req_fire;
   logic         req_valid_reg;
   logic [7:0]   rd_mux;

   wire req_wr     = req_valid_reg & ins_reg[`INS_WRITE_BIT];
   wire req_rd     = req_valid_reg & ~ins_reg[`INS_WRITE_BIT];
   wire req_to_sel = ins_reg[`INS_ADDR_BIT];
   wire wr_sel     = req_wr & req_to_sel;
   wire wr_reg     = req_wr & ~req_to_sel;
   wire rd_reg     = req_rd & ~req_to_sel;

   // frame sequencing on sampled clock rises
   always_comb begin
      fr_state_next = fr_state_reg;
      bit_cnt_next  = bit_cnt_reg;
      ins_next      = ins_reg;
      shift_next    = shift_reg;
      req_fire      = 1'b0;
      if (link_reset_reg) begin
         fr_state_next = FR_IDLE;
      end else if (req_rd) begin
         shift_next = rd_mux; // load read answer during turnaround
      end else if (ck_rise) begin
         case (fr_state_reg)
            FR_IDLE: begin
               if (!link_dt) begin
                  fr_state_next = FR_INS;
                  bit_cnt_next  = 3'h0;
               end
            end
            FR_INS: begin
               ins_next     = {link_dt, ins_reg[1]};
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == `INS_LAST_BIT) begin
                  bit_cnt_next = 3'h0;
                  if (ins_next[`INS_WRITE_BIT]) begin
                     fr_state_next = FR_DIN;
                  end else begin
                     fr_state_next = FR_TURN;
                     req_fire      = 1'b1;
                  end
               end
            end
            FR_DIN: begin
               shift_next   = {link_dt, shift_reg[7:1]};
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == `BYTE_LAST_BIT) begin
                  fr_state_next = FR_IDLE;
                  req_fire      = 1'b1;
               end
            end
            FR_TURN: begin
               fr_state_next = FR_DOUT;
            end
            FR_DOUT: begin
               shift_next   = {1'b0, shift_reg[7:1]};
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == `BYTE_LAST_BIT) begin
                  fr_state_next = FR_IDLE;
               end
            end
            default: begin
               fr_state_next = FR_IDLE;
            end
         endcase
      end
   end

   // frame registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fr_state_reg  <= FR_IDLE;
         bit_cnt_reg   <= 3'h0;
         ins_reg       <= 2'h0;
         shift_reg     <= 8'h00;
         req_valid_reg <= 1'b0;
      end else begin
         fr_state_reg  <= fr_state_next;
         bit_cnt_reg   <= bit_cnt_next;
         ins_reg       <= ins_next;
         shift_reg     <= shift_next;
         req_valid_reg <= req_fire;
      end
   end

   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   logic [7:0]  sel_reg;
   logic [7:0]  halt_reg;
   logic [7:0]  prog_reg;
   logic [7:0]  data_reg;
   logic [15:0] addr_reg;
   logic [31:0] crc_reg;
   logic        err_reg;
   logic        fetch_pend_reg;
   mem_state_t  mem_state_reg;
   mem_state_t  mem_state_next;
   crc_if       crc_bus ();

   function automatic logic sel_is(input logic [7:0] sel, input logic [7:0] adr);
      return sel == adr;
   endfunction : sel_is

   // target decode from the link address register
   wire hit_id   = sel_is(sel_reg, `ADR_PART_ID);
   wire hit_rev  = sel_is(sel_reg, `ADR_REV_ID);
   wire hit_halt = sel_is(sel_reg, `ADR_HALT);
   wire hit_prog = sel_is(sel_reg, `ADR_PROG_EN);
   wire hit_data = sel_is(sel_reg, `ADR_DATA);
   wire hit_stat = sel_is(sel_reg, `ADR_LOCK_STAT);
   wire hit_hi   = sel_is(sel_reg, `ADR_ADDR_HI);
   wire hit_lo   = sel_is(sel_reg, `ADR_ADDR_LO);
   wire hit_checksum_byte0 = sel_is(sel_reg, `ADR_CHECKSUM_BYTE0);
   wire hit_checksum_byte1 = sel_is(sel_reg, `ADR_CHECKSUM_BYTE1);
   wire hit_checksum_byte2 = sel_is(sel_reg, `ADR_CHECKSUM_BYTE2);
   wire hit_checksum_byte3 = sel_is(sel_reg, `ADR_CHECKSUM_BYTE3);

   // access gating and memory launch decisions
   wire halted    = (halt_reg != `REG_RESET);
   wire access_ok = halted & (prog_reg != `REG_RESET);
   wire mem_free  = (mem_state_reg == MS_IDLE) & ~crc_bus.busy;
   wire want_wr   = wr_reg & hit_data;
   wire want_rd   = (rd_reg & hit_data) | fetch_pend_reg;
   wire go_wr     = want_wr & mem_free & access_ok & ~i_write_locked;
   wire go_rd     = want_rd & mem_free & access_ok & ~i_read_locked & ~go_wr;
   wire err_set   = (want_wr | want_rd) & mem_free & ~go_wr & ~go_rd;
   wire go_crc    = crc_bus.mem_req & (mem_state_reg == MS_IDLE);
   wire mem_done  = i_mem_done & (mem_state_reg != MS_IDLE);
   wire link_done = mem_done & ((mem_state_reg == MS_LINK_RD) | (mem_state_reg == MS_LINK_WR));
   wire rd_done   = mem_done & (mem_state_reg == MS_LINK_RD);
   wire busy      = (mem_state_reg != MS_IDLE) | crc_bus.busy | fetch_pend_reg;
   wire crc_go    = wr_reg & (hit_checksum_byte0 | hit_checksum_byte1) & halted & mem_free;

   // next values of the software registers
   wire [7:0]  sel_next  = wr_sel ? shift_reg : sel_reg;
   wire [7:0]  halt_next = link_reset_reg ? `REG_RESET : ((wr_reg & hit_halt) ? shift_reg : halt_reg);
   wire [7:0]  prog_next = link_reset_reg ? `REG_RESET : ((wr_reg & hit_prog) ? shift_reg : prog_reg);
   wire [7:0]  data_next = rd_done ? i_mem_rdata : ((wr_reg & hit_data) ? shift_reg : data_reg);
   wire [15:0] addr_step = addr_reg + 16'h0001;
   wire [15:0] addr_next = link_done ? addr_step :
                           (wr_reg & hit_hi) ? {shift_reg, addr_reg[7:0]} :
                           (wr_reg & hit_lo) ? {addr_reg[15:8], shift_reg} : addr_reg;
   wire        err_next  = err_set | (err_reg & ~(go_wr | go_rd));

   // checksum bytes: byte writes, then a wide result replaces all four, a narrow result only the low two
   wire [31:0] crc_mask = {{8{wr_reg & hit_checksum_byte3}}, {8{wr_reg & hit_checksum_byte2}},
                           {8{wr_reg & hit_checksum_byte1}}, {8{wr_reg & hit_checksum_byte0}}};
   wire [31:0] crc_hold = (crc_reg & ~crc_mask) | ({4{shift_reg}} & crc_mask);
   wire [31:0] crc_wide = crc_bus.result;
   wire [31:0] crc_half = {crc_reg[31:16], crc_bus.result[15:0]};
   wire [31:0] crc_next = crc_bus.done ? (crc_bus.res_wide ? crc_wide : crc_half) : crc_hold;

   // answer bytes for link reads
   wire [7:0] status_byte = 8'(busy) << `STAT_BUSY_BIT;
   wire [7:0] lock_byte   = (8'(i_write_locked) << `STAT_WLOCK_BIT) |
                            (8'(i_read_locked) << `STAT_RLOCK_BIT) |
                            (8'(err_reg) << `STAT_ERR_BIT);
   assign rd_mux = req_to_sel ? status_byte :
                   hit_id     ? PART_ID :
                   hit_rev    ? REV_ID :
                   hit_halt   ? halt_reg :
                   hit_prog   ? prog_reg :
                   hit_data   ? data_reg :
                   hit_stat   ? lock_byte :
                   hit_hi     ? addr_reg[15:8] :
                   hit_lo     ? addr_reg[7:0] :
                   hit_checksum_byte0   ? crc_reg[7:0] :
                   hit_checksum_byte1   ? crc_reg[15:8] :
                   hit_checksum_byte2   ? crc_reg[23:16] :
                   hit_checksum_byte3   ? crc_reg[31:24] : 8'h00;

   // software register storage
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sel_reg        <= `REG_RESET;
         halt_reg       <= `REG_RESET;
         prog_reg       <= `REG_RESET;
         data_reg       <= `REG_RESET;
         addr_reg       <= 16'h0000;
         crc_reg        <= 32'h00000000;
         err_reg        <= 1'b0;
         fetch_pend_reg <= 1'b0;
      end else begin
         sel_reg        <= sel_next;
         halt_reg       <= halt_next;
         prog_reg       <= prog_next;
         data_reg       <= data_next;
         addr_reg       <= addr_next;
         crc_reg        <= crc_next;
         err_reg        <= err_next;
         fetch_pend_reg <= wr_reg & hit_lo;
      end
   end

   // ------------------------------------------------------------------
   // checksum engine and memory port
   // ------------------------------------------------------------------
   assign crc_bus.start    = crc_go;
   assign crc_bus.wide     = hit_checksum_byte1;
   assign crc_bus.base     = hit_checksum_byte1 ? `FULL_START_ADDR : {shift_reg, `BLOCK_LOW_ADDR};
   assign crc_bus.len      = hit_checksum_byte1 ? 17'(MEM_BYTES) : `BLOCK_BYTES;
   assign crc_bus.mem_ack  = mem_done & (mem_state_reg == MS_CRC);
   assign crc_bus.mem_data = i_mem_rdata;

   crc_engine #(
      .POLY16 (POLY16),
      .INIT16 (INIT16),
      .POLY32 (POLY32),
      .INIT32 (INIT32)
   ) u_crc_engine (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .bus    (crc_bus)
   );

   // memory access sequencing, checksum fetches first
   always_comb begin
      mem_state_next = mem_state_reg;
      case (mem_state_reg)
         MS_IDLE: begin
            if (go_crc) begin
               mem_state_next = MS_CRC;
            end else if (go_wr) begin
               mem_state_next = MS_LINK_WR;
            end else if (go_rd) begin
               mem_state_next = MS_LINK_RD;
            end
         end
         MS_LINK_RD, MS_LINK_WR, MS_CRC: begin
            if (i_mem_done) begin
               mem_state_next = MS_IDLE;
            end
         end
         default: begin
            mem_state_next = MS_IDLE;
         end
      endcase
   end

   wire [15:0] launch_addr = go_crc ? crc_bus.mem_addr : addr_reg;
   wire        launch      = (mem_state_reg == MS_IDLE) & (go_crc | go_wr | go_rd);

   // memory port registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mem_state_reg <= MS_IDLE;
         o_mem_addr    <= 16'h0000;
         o_mem_wdata   <= 8'h00;
         o_mem_read    <= 1'b0;
         o_mem_write   <= 1'b0;
      end else begin
         mem_state_reg <= mem_state_next;
         o_mem_addr    <= launch ? launch_addr : o_mem_addr;
         o_mem_wdata   <= go_wr ? shift_reg : o_mem_wdata;
         o_mem_read    <= (mem_state_next == MS_LINK_RD) | (mem_state_next == MS_CRC);
         o_mem_write   <= (mem_state_next == MS_LINK_WR);
      end
   end

   // pin and core control outputs
   assign o_link_data_pin = shift_reg[0];
   assign o_link_data_oe  = (fr_state_reg == FR_DOUT);
   assign o_core_reset    = link_reset_reg;
   assign o_core_halt     = halted;
   assign o_prog_enable   = access_ok;
   assign o_lock_addr     = addr_reg;
endmodule : dbg_prog_port
`default_nettype wire

//--- dv/dbg_prog_port_assertions.sv
// assertions on the programming port pins
`timescale 1ns/10ps
`default_nettype none
module dbg_prog_port_assertions (
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic        i_link_clock_pin,
   input wire logic        i_mem_done,
   input wire logic        o_core_reset,
   input wire logic        o_core_halt,
   input wire logic        o_prog_enable,
   input wire logic        o_link_data_oe,
   input wire logic        o_mem_read,
   input wire logic        o_mem_write,
   input wire logic [15:0] o_mem_addr,
   input wire logic [7:0]  o_mem_wdata
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   logic [9:0] low_cnt;
   // cycles spent with the link clock low
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) low_cnt <= 10'h000;
      else low_cnt <= i_link_clock_pin ? 10'h000 : low_cnt + 10'h001;
   end
   sequence req_wait; (o_mem_read || o_mem_write) && !i_mem_done; endsequence
   sequence req_end; (o_mem_read || o_mem_write) && i_mem_done; endsequence
   a_req_stable: assert property (req_wait |=> $stable({o_mem_read, o_mem_write, o_mem_addr, o_mem_wdata}))
      else $error("request changed before done");
   a_req_drop: assert property (req_end |=> !o_mem_read && !o_mem_write)
      else $error("request held after done");
   a_one_req: assert property (!(o_mem_read && o_mem_write))
      else $error("read and write together");
   a_prog_halt: assert property (o_prog_enable |-> o_core_halt)
      else $error("program enable without halt");
   a_link_rst: assert property (low_cnt > 10'd510 |-> o_core_reset && !o_core_halt)
      else $error("long low clock did not reset");
   a_no_spur: assert property (low_cnt inside {[10'd8:10'd495]} |-> !o_core_reset)
      else $error("core reset too early");
   a_rst_rel: assert property ($rose(i_link_clock_pin) |-> ##[1:8] !o_core_reset)
      else $error("core reset stuck");
   a_oe_hold: assert property ($rose(o_link_data_oe) |-> o_link_data_oe[*8])
      else $error("read drive too short");
endmodule : dbg_prog_port_assertions
bind dbg_prog_port dbg_prog_port_assertions u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_link_clock_pin(i_link_clock_pin), .i_mem_done(i_mem_done), .o_core_reset(o_core_reset),
   .o_core_halt(o_core_halt), .o_prog_enable(o_prog_enable), .o_link_data_oe(o_link_data_oe),
   .o_mem_read(o_mem_read), .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata));
`default_nettype wire

//--- dv/link_tool.sv
// model of the programming tool on the two-wire link
`timescale 1ns/10ps
`default_nettype none
module link_tool (
   input  wire logic i_dev_dat,
   input  wire logic i_dev_oe,
   output var  logic o_clk,
   output wire logic o_wire
);
   logic drv = 1'b1;
   initial o_clk = 1'b1;
   // wire level: device wins while it drives
   assign o_wire = i_dev_oe ? i_dev_dat : drv;
   // one bit: data set on the fall, sampled on the rise
   task automatic tick(input logic b, output logic s);
      o_clk = 1'b0;
      drv = b;
      #160;
      o_clk = 1'b1;
      s = o_wire;
      #160;
   endtask : tick
   // start, write flag, address flag, a turnaround bit on reads, then byte lsb first
   task automatic frame(input logic wr, ad, input logic [7:0] wd, output logic [7:0] rd);
      logic s;
      tick(1'b0, s);
      tick(wr, s);
      tick(ad, s);
      if (!wr) tick(~drv, s);
      for (int k = 0; k < 8; k++) begin
         tick(wr ? wd[k] : ~drv, s); // released: toggling pattern
         rd[k] = s;
      end
   endtask : frame
   // long low clock resets the core
   task automatic hold(input int ns);
      o_clk = 1'b0;
      #(ns);
      o_clk = 1'b1;
      #320;
   endtask : hold
endmodule : link_tool
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the programming port
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic i_clk = 1'b0, i_rstn = 1'b0, i_mem_done = 1'b0, i_write_locked = 1'b0, i_read_locked = 1'b0;
   logic [7:0] i_mem_rdata = 8'h00, rv, mem [256];
   logic [7:0] regs [10] = '{8'h02, 8'hDF, 8'hAF, 8'hAE, 8'hB7, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hBF};
   logic [15:0] q [$], o_mem_addr, o_lock_addr;
   logic [7:0] o_mem_wdata;
   logic o_mem_read, o_mem_write, dev_dat, dev_oe, lclk, lwire;
   int miscompares = 0, tests_run = 0, seed = 59, cyc = 0;
   event got;
   initial forever #20 i_clk = ~i_clk;
   link_tool tool (.i_dev_dat(dev_dat), .i_dev_oe(dev_oe), .o_clk(lclk), .o_wire(lwire));
   dbg_prog_port #(.MEM_BYTES(256)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_clock_pin(lclk),
      .i_link_data_pin(lwire), .o_link_data_pin(dev_dat), .o_link_data_oe(dev_oe), .o_core_reset(),
      .o_core_halt(), .o_prog_enable(), .o_lock_addr(o_lock_addr), .i_write_locked(i_write_locked),
      .i_read_locked(i_read_locked), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
      .o_mem_read(o_mem_read), .o_mem_write(o_mem_write), .i_mem_rdata(i_mem_rdata), .i_mem_done(i_mem_done));
   // memory with random latency, lock window on 0x0043, timeout
   always @(negedge i_clk) begin
      cyc++;
      if (cyc > 40000) begin
         miscompares++;
         end_of_test();
      end
      i_write_locked = (o_lock_addr == 16'h0043);
      i_read_locked = (o_lock_addr == 16'h0043);
      i_mem_done = (o_mem_read || o_mem_write) && !i_mem_done && ($random(seed) & 1);
      i_mem_rdata = mem[o_mem_addr[7:0]];
      if (i_mem_done && o_mem_write) mem[o_mem_addr[7:0]] = o_mem_wdata;
   end
   // oldest expectation against the byte read back
   always @(got) begin
      tests_run++;
      if (rv !== q[0][7:0]) begin
         miscompares++;
         $display("[ERR] reg_%h exp %h got %h", q[0][15:8], q[0][7:0], rv);
      end
      void'(q.pop_front());
   end
   task automatic put(input logic [7:0] a, d);
      tool.frame(1'b1, 1'b1, a, rv);
      tool.frame(1'b1, 1'b0, d, rv);
   endtask : put
   task automatic get(input logic [7:0] a, e);
      q.push_back({a, e});
      tool.frame(1'b1, 1'b1, a, rv);
      tool.frame(1'b0, 1'b0, 8'h00, rv);
      ->got;
   endtask : get
   // poll the status until the busy bit clears
   task automatic idle;
      for (int i = 0; i < 60; i++) begin
         tool.frame(1'b0, 1'b1, 8'h00, rv);
         if (!rv[7]) return;
      end
      miscompares++;
      $display("[ERR] busy exp 0 got 1");
   endtask : idle
   // msb-first checksum over the 256-byte memory
   function automatic logic [31:0] crc(input logic w);
      logic [31:0] c;
      c = w ? 32'hFFFFFFFF : 32'h0000FFFF;
      for (int i = 0; i < 256; i++) begin
         c = c ^ (w ? {mem[i], 24'h000000} : {16'h0000, mem[i], 8'h00});
         for (int b = 0; b < 8; b++) c = (w ? c[31] : c[15]) ? (c << 1) ^ (w ? 32'h04C11DB7 : 32'h00001021) : c << 1;
      end
      return w ? c : {16'h0000, c[15:0]};
   endfunction : crc
   task automatic end_of_test;
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial begin
      logic [31:0] c;
      logic [7:0] rnd;
      foreach (mem[i]) mem[i] = 8'($random(seed));
      rnd = 8'($random(seed));
      repeat (2) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (6) @(negedge i_clk);
      foreach (regs[i]) get(regs[i], 8'h00);
      get(8'h00, 8'h5A);
      get(8'h01, 8'h00);
      get(8'h55, 8'h00);
      put(8'h02, 8'h01);
      get(8'h02, 8'h01);
      put(8'hDF, 8'h01);
      put(8'hAF, 8'h00);
      put(8'hAE, 8'h10);
      idle();
      get(8'hBF, mem[16]);
      idle();
      put(8'hBF, rnd);
      idle();
      put(8'hAE, 8'h12);
      idle();
      get(8'hBF, rnd);
      idle();
      put(8'hAE, 8'h42);
      idle();
      get(8'hB7, 8'hC0);
      put(8'hBF, 8'hA5);
      get(8'hB7, 8'hC1);
      put(8'hA9, 8'h00);
      idle();
      c = crc(1'b0);
      get(8'hA9, c[7:0]);
      get(8'hAA, c[15:8]);
      put(8'hAA, 8'h00);
      idle();
      c = crc(1'b1);
      for (int i = 0; i < 4; i++) get(8'(8'hA9 + i), c[8*i+:8]);
      tool.hold(21000);
      get(8'h02, 8'h00);
      get(8'hDF, 8'h00);
      // let the last queued compare run before the verdict
      @(negedge i_clk);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
